/* File: src/lfs_pkg.sv */
package lfs_pkg;
    localparam int LFS_NUM_CH         = 4;
    localparam int LFS_TIMEOUT_PWM    = 6;
    localparam int LFS_TIMEOUT_DIR    = 12;
    localparam int LFS_TIMEOUT_DIR_LO = 7;
    localparam int LFS_TIMEOUT_DIR_HI = 18;
    localparam int LFS_CNT_W          = 5;
endpackage : lfs_pkg

/* File: src/lfs_channel_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module lfs_channel_timer
    import lfs_pkg::*;
#(
    parameter int CNT_W = LFS_CNT_W
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fault timing
    input  wire logic             fault,
    input  wire logic             tick,
    input  wire logic [CNT_W-1:0] limit,
    // Result
    output logic                  expired
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             next_expired;

    if (CNT_W < 1) begin : g_chk_cnt_w
        $error("lfs_channel_timer: CNT_W must be at least 1");
    end

    always_comb begin
        next_count   = count;
        next_expired = expired;
        if (!fault) begin
            next_count = '0;
        end else if (tick && !expired) begin
            if (count + 1'b1 >= limit) begin
                next_expired = 1'b1;
            end
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count   <= '0;
            expired <= 1'b0;
        end else begin
            count   <= next_count;
            expired <= next_expired;
        end
    end
endmodule : lfs_channel_timer
`default_nettype wire

/* File: src/lfs_supervisor.sv */
`timescale 1ns/10ps
`default_nettype none
module lfs_supervisor
    import lfs_pkg::*;
#(
    parameter int NUM_CH      = lfs_pkg::LFS_NUM_CH,
    parameter int TIMEOUT_DIR = lfs_pkg::LFS_TIMEOUT_DIR
) (
    // Clock and reset; rst stands for the power cycle.
    input  wire logic              clk,
    input  wire logic              rst,
    // Comparator flags
    input  wire logic [NUM_CH-1:0] short_threshold_detect,
    input  wire logic [NUM_CH-1:0] current_good,
    input  wire logic              output_overvoltage_flag,
    input  wire logic              over_temp,
    // Timing and mode
    input  wire logic              pwm_cycle_tick,
    input  wire logic              pass_through_dimming_mode,
    input  wire logic              zener_mode_latch,
    // Channel control
    output logic [NUM_CH-1:0]      led_channel_n_en,
    output logic [NUM_CH-1:0]      channel_faulted,
    output logic                   thermal_shutdown,
    output logic                   boost_enable
);
    import lfs_pkg::*;

    // Good flags: one bit per channel, set once the channel has reached target current.
    logic [NUM_CH-1:0]    good;
    logic [NUM_CH-1:0]    next_good;

    // Fault timing: candidates per channel and the time-out results.
    logic [LFS_CNT_W-1:0] limit;
    logic [NUM_CH-1:0]    fault_cond;
    logic [NUM_CH-1:0]    timer_fault;
    logic [NUM_CH-1:0]    expired;

    // Latched channel faults, held until power is cycled.
    logic [NUM_CH-1:0]    latched_off;
    logic [NUM_CH-1:0]    next_latched_off;

    // Thermal state of the whole chip.
    logic                 any_short;
    logic                 power_lock;
    logic                 next_power_lock;
    logic                 next_thermal;

    // Next values of the registered outputs.
    logic [NUM_CH-1:0]    next_en;
    logic [NUM_CH-1:0]    next_faulted;
    logic                 next_boost;

    // Elaboration-time checks: refuse values that the counters and masks cannot serve.
    if (NUM_CH < 1) begin : g_chk_num_ch
        $error("lfs_supervisor: NUM_CH must be at least 1");
    end
    if (TIMEOUT_DIR < LFS_TIMEOUT_DIR_LO || TIMEOUT_DIR > LFS_TIMEOUT_DIR_HI) begin : g_chk_timeout
        $error("lfs_supervisor: TIMEOUT_DIR outside the pass-through time-out range");
    end
    if ((2 ** LFS_CNT_W) <= LFS_TIMEOUT_DIR_HI) begin : g_chk_cnt_w
        $error("lfs_supervisor: counter too narrow for the longest time-out");
    end

    // Time-out limits, both cut to the counter width on purpose.
    localparam logic [LFS_CNT_W-1:0] LIM_PWM = LFS_CNT_W'(LFS_TIMEOUT_PWM);
    localparam logic [LFS_CNT_W-1:0] LIM_DIR = LFS_CNT_W'(TIMEOUT_DIR);

    // Every channel goes dark while overheat holds or after the chip has locked itself off.
    function automatic logic chip_off(input logic thermal, input logic lock);
        chip_off = thermal | lock;
    endfunction

    // Fault candidate of one channel: above the short threshold, lost its current after having
    // reached target, or never proven good while the output sits at the over-voltage limit.
    function automatic logic fault_candidate(
        input logic over_short,
        input logic was_good,
        input logic at_target,
        input logic overvoltage
    );
        logic lost_current;
        logic not_proven;
        lost_current    = was_good & ~at_target;
        not_proven      = overvoltage & ~was_good;
        fault_candidate = over_short | lost_current | not_proven;
    endfunction

    // The good mark is kept until power is cycled, so that a later loss of current reads as an
    // open circuit rather than as a channel that has never started.
    always_comb begin
        next_good = good | current_good;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            good <= '0;
        end else begin
            good <= next_good;
        end
    end

    // Only a lit channel can fail. A dark channel has no current, and counting it would let
    // every good channel time out during an overheat and stay off after the chip has cooled.
    // A candidate that goes away before its count completes clears the count in its timer.
    always_comb begin
        limit = pass_through_dimming_mode ? LIM_DIR : LIM_PWM;
        for (int i = 0; i < NUM_CH; i++) begin
            fault_cond[i]  = fault_candidate(short_threshold_detect[i], good[i], current_good[i],
                                             output_overvoltage_flag);
            timer_fault[i] = fault_cond[i] & led_channel_n_en[i] & ~latched_off[i];
        end
    end

    // One time-out counter per channel, all counting dimming cycles on the shared tick.
    for (genvar g = 0; g < NUM_CH; g++) begin : g_timer
        lfs_channel_timer #(
            .CNT_W (LFS_CNT_W)
        ) u_timer (
            .clk     (clk),
            .rst     (rst),
            .fault   (timer_fault[g]),
            .tick    (pwm_cycle_tick),
            .limit   (limit),
            .expired (expired[g])
        );
    end

    // A channel whose time-out has run out stays off until power is cycled.
    always_comb begin
        next_latched_off = latched_off | expired;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            latched_off <= '0;
        end else begin
            latched_off <= next_latched_off;
        end
    end

    // Overheat while no channel sits above the short threshold points at a hard short that burns
    // power in a sink. With plain LEDs that is not recoverable, so the chip stays off until power
    // is cycled. With zener-bypassed strings the overheat holds the channels off only while it lasts.
    always_comb begin
        any_short       = |short_threshold_detect;
        next_power_lock = power_lock;
        if (over_temp && !zener_mode_latch && !any_short) begin
            next_power_lock = 1'b1;
        end
        next_thermal    = chip_off(over_temp, next_power_lock);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            power_lock       <= 1'b0;
            thermal_shutdown <= 1'b0;
        end else begin
            power_lock       <= next_power_lock;
            thermal_shutdown <= next_thermal;
        end
    end

    // Channels below the threshold without overheat simply keep running, shorted or bypassed.
    // The boost stops together with the sinks, and also when no channel is left to regulate.
    always_comb begin
        next_en      = ~next_latched_off;
        if (chip_off(over_temp, next_power_lock)) begin
            next_en = '0;
        end
        next_faulted = next_latched_off;
        next_boost   = ~chip_off(over_temp, next_power_lock) & (|next_en);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            led_channel_n_en <= '0;
            channel_faulted  <= '0;
            boost_enable     <= 1'b0;
        end else begin
            led_channel_n_en <= next_en;
            channel_faulted  <= next_faulted;
            boost_enable     <= next_boost;
        end
    end
endmodule : lfs_supervisor
`default_nettype wire

/* File: testbench/lfs_supervisor_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module lfs_supervisor_monitor #(parameter int NUM_CH = 4) (
    input wire logic clk, rst, over_temp, zener_mode_latch, pwm_cycle_tick, thermal_shutdown, boost_enable,
    input wire logic [NUM_CH-1:0] short_threshold_detect, current_good, led_channel_n_en, channel_faulted
);
    logic [NUM_CH-1:0] last;
    wire [NUM_CH-1:0] fresh = channel_faulted & ~last;
    always_ff @(posedge clk) last <= rst ? '0 : channel_faulted;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_off; over_temp |=> led_channel_n_en == '0; endproperty
    a_off: assert property (p_off) else $error("on in overheat");
    property p_th; over_temp |=> thermal_shutdown; endproperty
    a_th: assert property (p_th) else $error("no shutdown");
    property p_why; $rose(thermal_shutdown) |-> $past(over_temp); endproperty
    a_why: assert property (p_why) else $error("shutdown unprompted");
    property p_lock; over_temp && !zener_mode_latch && short_threshold_detect == '0
        |=> thermal_shutdown [*8]; endproperty
    a_lock: assert property (p_lock) else $error("lock lost");
    property p_keep; (last & ~channel_faulted) == '0; endproperty
    a_keep: assert property (p_keep) else $error("fault dropped");
    property p_dead; (led_channel_n_en & channel_faulted) == '0; endproperty
    a_dead: assert property (p_dead) else $error("faulted channel on");
    property p_tick; fresh != '0 |-> $past(pwm_cycle_tick, 2); endproperty
    a_tick: assert property (p_tick) else $error("fault off tick");
    property p_held; (fresh & ~($past(short_threshold_detect, 2) | ~$past(current_good, 2))) == '0; endproperty
    a_held: assert property (p_held) else $error("fault uncaused");
    property p_boost; thermal_shutdown |-> !boost_enable; endproperty
    a_boost: assert property (p_boost) else $error("boost on in shutdown");
    c_fault: cover property (fresh != '0);
    c_lock: cover property (over_temp && !zener_mode_latch);
    c_free: cover property ($fell(thermal_shutdown));
endmodule // lfs_supervisor_monitor
bind lfs_supervisor lfs_supervisor_monitor #(.NUM_CH(NUM_CH)) u_mon (.*);
`default_nettype wire

/* File: testbench/lfs_led_model.sv */
`timescale 1ns/10ps
`default_nettype none
module lfs_led_model (
    input wire logic clk, boost_enable,
    input wire logic [3:0] led_channel_n_en, open_m, short_m,
    output logic [3:0] current_good, short_threshold_detect,
    output logic output_overvoltage_flag
);
    always_ff @(posedge clk) current_good <= led_channel_n_en & ~open_m;
    assign short_threshold_detect = short_m & led_channel_n_en;
    assign output_overvoltage_flag = boost_enable & |(led_channel_n_en & open_m);
endmodule // lfs_led_model
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import lfs_pkg::*;
    logic clk = 0, rst = 1, over_temp = 0, pwm_cycle_tick = 0, pass_through_dimming_mode = 0, zener_mode_latch = 1;
    logic chk = 0, boost_enable, output_overvoltage_flag, thermal_shutdown;
    logic [3:0] open_m = 0, short_m = 0, short_threshold_detect, current_good, led_channel_n_en, channel_faulted;
    logic [8:0] q [$];
    int n_fail = 0, comparisons = 0;
    initial forever #2 clk = ~clk;
    lfs_supervisor uut (.*);
    lfs_led_model far (.*);
    task automatic wrap_up();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        comparisons++;
        if (seen !== want) begin
            n_fail++;
            $display("BAD outputs expected %h seen %h", want, seen);
        end
    endtask
    always @(posedge clk) if (chk) check({led_channel_n_en, channel_faulted, thermal_shutdown}, q.pop_front());
    // Tick spacing is random so that a count of clock cycles cannot pass for a count of ticks.
    task automatic ex(input int n, input logic [8:0] v);
        repeat (n) begin
            @(posedge clk) pwm_cycle_tick <= 1;
            @(posedge clk) pwm_cycle_tick <= 0;
            repeat ($urandom_range(3)) @(posedge clk);
        end
        repeat (3) @(posedge clk);
        for (int i = 0; i < 40 && led_channel_n_en !== v[8:5]; i++) @(posedge clk);
        if (led_channel_n_en !== v[8:5]) begin
            n_fail++;
            wrap_up();
        end
        q.push_back(v);
        chk <= 1;
        @(posedge clk) chk <= 0;
        @(posedge clk);
    endtask
    initial begin
        void'($urandom(32'h4ee0));
        repeat (20) @(posedge clk);
        rst <= 0;
        ex(0, 9'h1E0);
        short_m <= 4'h1;
        ex(3, 9'h1E0);
        short_m <= 4'h0;
        ex(1, 9'h1E0);
        short_m <= 4'h1;
        ex(LFS_TIMEOUT_PWM - 1, 9'h1E0);
        ex(1, 9'h1C2);
        $display("short test done");
        pass_through_dimming_mode <= 1;
        open_m <= 4'h2;
        ex(LFS_TIMEOUT_DIR - 1, 9'h1C2);
        ex(1, 9'h186);
        $display("open test done");
        over_temp <= 1;
        ex(0, 9'h007);
        over_temp <= 0;
        ex(0, 9'h186);
        zener_mode_latch <= 0;
        over_temp <= 1;
        ex(0, 9'h007);
        over_temp <= 0;
        ex(0, 9'h007);
        $display("overheat test done");
        rst <= 1;
        zener_mode_latch <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        ex(0, 9'h1E0);
        $display("reset test done");
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
